// file: cfd_pkg.sv
package cfd_pkg;

  // Channel count and per-channel field width
  localparam int NCH = 8;
  localparam int MODE_W = 2;

  // Clock rate
  localparam int CLK_FREQ_MHZ = 125;

  // Filter times in ns and derived cycle counts (least times round up)
  localparam int OFF_FILT_NS = 50000;
  localparam int OFF_FILT_CYC = (OFF_FILT_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int OVL_DELAY_NS = 20000;
  localparam int OVL_DELAY_CYC = (OVL_DELAY_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int HOT_FILT_NS = 1000;
  localparam int HOT_FILT_CYC = (HOT_FILT_NS * CLK_FREQ_MHZ + 999) / 1000;

  // Channel mode codes, two bits per channel
  localparam logic [1:0] MODE_CLEAR = 2'h0;
  localparam logic [1:0] MODE_ON = 2'h1;
  localparam logic [1:0] MODE_INPUT = 2'h2;
  localparam logic [1:0] MODE_OFF = 2'h3;

  // Register byte offsets
  localparam logic [4:0] ADDR_MODE = 5'h00;
  localparam logic [4:0] ADDR_DIAG = 5'h04;
  localparam logic [4:0] ADDR_IRQ_STATUS = 5'h08;
  localparam logic [4:0] ADDR_IRQ_ENABLE = 5'h0C;
  localparam logic [4:0] ADDR_IRQ_CLEAR = 5'h10;

  // Values after reset
  localparam logic [15:0] MODE_RESET = 16'hFFFF;
  localparam logic [7:0] IRQ_RESET = 8'h00;

  // Default two-bit fault codes
  localparam logic [1:0] CODE_NONE_DEF = 2'h0;
  localparam logic [1:0] CODE_OPEN_DEF = 2'h1;
  localparam logic [1:0] CODE_GND_DEF = 2'h2;
  localparam logic [1:0] CODE_BAT_DEF = 2'h3;
  localparam logic [1:0] CODE_HOT_DEF = 2'h3;

  // Stored fault kind of one channel
  typedef enum logic [2:0] {
    FLT_NONE,
    FLT_OPEN_LOAD,
    FLT_GROUND_SHORT,
    FLT_BATTERY_SHORT,
    FLT_OVERTEMP
  } cfd_fault_type;

endpackage

// file: cfd_diag.sv
// Design decisions made here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Function
// R1 - Overload is checked only while the stage is on: ON, or input high.
// R2 - Ground short and open load are checked only while the stage is off.
// R3 - Overtemperature while on stores the fault, turns off, needs clear mode to return.
// R4 - Overtemperature while clamping stores the fault; restart needs cool, no clamp, clear.
// R5 - Overtemperature while off without clamping stores nothing; restart automatic once cool.
// R6 - Clear mode disables detection and the diagnosis current sources.
// R7 - Every channel has its own two-bit fault field, eight fields in all.
// R8 - Ground short replaces open load; open load never replaces ground short.
// R9 - Host passes clear mode then an off mode to see open load after ground short.
// R10 - Off-state level: above open-load threshold fine, between open load, below ground short.
// R11 - Overload turns the channel off after the delay and latches; clear mode re-enables.
// R12 - Battery short replaces a stored open-load or ground-short code.
// R13 - With battery short stored, off-state faults are not recorded until clear mode.
// R14 - After clear, an off mode re-arms detection; result readable on next access.
// R15 - Host puts all channels into clear mode after power-on before trusting diagnosis.
// R16 - All four faults are recorded only after persisting for their filter time.
// R17 - Off-state filter time lies between 30 and 200 microseconds.
// R18 - The two-bit fault encoding is a design parameter.
module cfd_diag #(
  parameter logic [15:0] OFF_FILT_CYC = 16'(cfd_pkg::OFF_FILT_CYC),
  parameter logic [1:0] CODE_NONE = cfd_pkg::CODE_NONE_DEF,
  parameter logic [1:0] CODE_OPEN = cfd_pkg::CODE_OPEN_DEF,
  parameter logic [1:0] CODE_GND = cfd_pkg::CODE_GND_DEF,
  parameter logic [1:0] CODE_BAT = cfd_pkg::CODE_BAT_DEF,
  parameter logic [1:0] CODE_HOT = cfd_pkg::CODE_HOT_DEF
) (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // Avalon-MM slave
  input wire logic [4:0] ADDRESS_IN,
  input wire logic READ_IN,
  input wire logic WRITE_IN,
  input wire logic [31:0] WRITEDATA_IN,
  input wire logic [3:0] BYTEENABLE_IN,
  output logic [31:0] READDATA_OUT,
  output logic WAITREQUEST_OUT,
  // Per-channel analog and pin status
  input wire logic [cfd_pkg::NCH-1:0] PARALLEL_INPUT_IN,
  input wire logic [cfd_pkg::NCH-1:0] ABOVE_OPEN_LOAD_THRESHOLD_IN,
  input wire logic [cfd_pkg::NCH-1:0] BELOW_GROUND_SHORT_THRESHOLD_IN,
  input wire logic [cfd_pkg::NCH-1:0] OVERLOAD_IN,
  input wire logic [cfd_pkg::NCH-1:0] THERMAL_TRIP_IN,
  input wire logic [cfd_pkg::NCH-1:0] CLAMPING_IN,
  // Per-channel controls and the shared interrupt output
  output logic [cfd_pkg::NCH-1:0] GATE_ON_OUT,
  output logic [cfd_pkg::NCH-1:0] DIAG_CURRENT_EN_OUT,
  output logic IRQ_OUT
);
  import cfd_pkg::*;

  localparam logic [15:0] OVL_CYC = 16'(OVL_DELAY_CYC);
  localparam logic [15:0] HOT_CYC = 16'(HOT_FILT_CYC);

  // Bus, status and synchroniser state
  logic [15:0] mode_reg;
  logic [7:0] irq_status_reg;
  logic [7:0] irq_enable_reg;
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic irq_reg;
  logic [5:0][NCH-1:0] meta_reg;
  logic [5:0][NCH-1:0] sync_reg;
  wire [NCH-1:0] gate_w;
  wire [NCH-1:0] cur_w;
  wire [NCH-1:0] evt_w;
  wire [15:0] diag_w;
  logic [31:0] rdata_next;
  logic [7:0] clr_bits;
  logic wr_take;

  // Two-flop synchronisers for all pin and comparator inputs
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= {CLAMPING_IN, THERMAL_TRIP_IN, OVERLOAD_IN,
                   BELOW_GROUND_SHORT_THRESHOLD_IN, ABOVE_OPEN_LOAD_THRESHOLD_IN,
                   PARALLEL_INPUT_IN};
      sync_reg <= meta_reg;
    end
  end

  // Per-channel fault detection and output stage control
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_ch
      // Local signals of one channel
      logic [1:0] mode;
      logic pin, above_open, below_gnd, ovl, trip, clamp;
      logic clear, on_req, on_stage, off_stage;
      logic ovl_c, hot_c, gnd_c, open_c;
      logic ovl_hit, hot_hit, gnd_hit, open_hit;
      logic [15:0] ovl_cnt_reg;
      logic [15:0] hot_cnt_reg;
      logic [15:0] gnd_cnt_reg;
      logic [15:0] open_cnt_reg;
      logic lock_reg;
      logic gate_reg;
      logic cur_reg;
      logic evt_reg;
      cfd_fault_type fault_reg;
      cfd_fault_type fault_next;

      // Mode field and synchronised inputs of this channel
      assign mode = mode_reg[2*ch +: 2];
      assign pin = sync_reg[0][ch];
      assign above_open = sync_reg[1][ch];
      assign below_gnd = sync_reg[2][ch];
      assign ovl = sync_reg[3][ch];
      assign trip = sync_reg[4][ch];
      assign clamp = sync_reg[5][ch];
      // Stage decode
      assign clear = (mode == MODE_CLEAR); // R6
      assign on_req = (mode == MODE_ON) || (mode == MODE_INPUT && pin);
      assign on_stage = on_req && !lock_reg; // R1
      assign off_stage = !clear && !on_req; // R2
      // Fault conditions, gated by stage state
      assign ovl_c = on_stage && ovl; // R1
      assign hot_c = trip && (on_stage || (off_stage && clamp)); // R3 R4 R5
      assign gnd_c = off_stage && below_gnd; // R10
      assign open_c = off_stage && !below_gnd && !above_open; // R10
      // Filter end points, one cycle before the counter saturates
      assign ovl_hit = ovl_c && (ovl_cnt_reg == OVL_CYC - 16'h0001); // R11 R16
      assign hot_hit = hot_c && (hot_cnt_reg == HOT_CYC - 16'h0001); // R16
      assign gnd_hit = gnd_c && (gnd_cnt_reg == OFF_FILT_CYC - 16'h0001); // R16 R17
      assign open_hit = open_c && (open_cnt_reg == OFF_FILT_CYC - 16'h0001); // R16 R17

      // Persistence counters, restart whenever the condition drops
      always_ff @(posedge CLK_IN) begin
        if (RST_IN || !ovl_c) begin
          ovl_cnt_reg <= 16'h0000;
        end else if (ovl_cnt_reg != OVL_CYC) begin
          ovl_cnt_reg <= ovl_cnt_reg + 16'h0001;
        end
      end

      always_ff @(posedge CLK_IN) begin
        if (RST_IN || !hot_c) begin
          hot_cnt_reg <= 16'h0000;
        end else if (hot_cnt_reg != HOT_CYC) begin
          hot_cnt_reg <= hot_cnt_reg + 16'h0001;
        end
      end

      always_ff @(posedge CLK_IN) begin
        if (RST_IN || !gnd_c) begin
          gnd_cnt_reg <= 16'h0000;
        end else if (gnd_cnt_reg != OFF_FILT_CYC) begin
          gnd_cnt_reg <= gnd_cnt_reg + 16'h0001;
        end
      end

      always_ff @(posedge CLK_IN) begin
        if (RST_IN || !open_c) begin
          open_cnt_reg <= 16'h0000;
        end else if (open_cnt_reg != OFF_FILT_CYC) begin
          open_cnt_reg <= open_cnt_reg + 16'h0001;
        end
      end

      // Fault field update with overwrite priorities
      always_comb begin
        fault_next = fault_reg;
        if (clear) begin
          fault_next = FLT_NONE; // R6
        end else if (ovl_hit) begin
          fault_next = FLT_BATTERY_SHORT; // R12
        end else if (hot_hit) begin
          fault_next = FLT_OVERTEMP; // R3 R4
        end else if (gnd_hit && fault_reg != FLT_BATTERY_SHORT &&
                     fault_reg != FLT_OVERTEMP) begin
          fault_next = FLT_GROUND_SHORT; // R8 R13 R14
        end else if (open_hit && fault_reg == FLT_NONE) begin
          fault_next = FLT_OPEN_LOAD; // R8 R13 R14
        end
      end

      // Field register and a one-cycle event towards the status bits
      always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
          fault_reg <= FLT_NONE;
          evt_reg <= 1'b0;
        end else begin
          fault_reg <= fault_next;
          evt_reg <= (fault_next != fault_reg) && (fault_next != FLT_NONE);
        end
      end

      // Shutdown latch: held until clear mode and every cause has gone
      always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
          lock_reg <= 1'b0;
        end else if (ovl_hit || hot_hit) begin
          lock_reg <= 1'b1; // R3 R4 R11
        end else if (clear && !trip && !ovl && !clamp) begin
          lock_reg <= 1'b0; // R3 R4 R11
        end
      end

      // Output stage and diagnosis current sources
      always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
          gate_reg <= 1'b0;
          cur_reg <= 1'b0;
        end else begin
          gate_reg <= on_stage && !trip && !ovl_hit && !hot_hit; // R5
          cur_reg <= !clear; // R6
        end
      end

      assign gate_w[ch] = gate_reg;
      assign cur_w[ch] = cur_reg;
      assign evt_w[ch] = evt_reg;
      // Encoded two-bit field of this channel
      assign diag_w[2*ch +: 2] = (fault_reg == FLT_OPEN_LOAD) ? CODE_OPEN : // R7 R18
                                 (fault_reg == FLT_GROUND_SHORT) ? CODE_GND :
                                 (fault_reg == FLT_BATTERY_SHORT) ? CODE_BAT :
                                 (fault_reg == FLT_OVERTEMP) ? CODE_HOT : CODE_NONE;
    end
  endgenerate

  // A request is taken on the edge that sees waitrequest low
  assign wr_take = WRITE_IN && !wait_reg;

  // Read mux, unmapped and write-only offsets read as zero
  always_comb begin
    rdata_next = 32'h00000000;
    case (ADDRESS_IN)
      ADDR_MODE: rdata_next = {16'h0000, mode_reg};
      ADDR_DIAG: rdata_next = {16'h0000, diag_w};
      ADDR_IRQ_STATUS: rdata_next = {24'h000000, irq_status_reg};
      ADDR_IRQ_ENABLE: rdata_next = {24'h000000, irq_enable_reg};
      default: rdata_next = 32'h00000000;
    endcase
  end

  // One wait cycle per access, then the answer
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      wait_reg <= 1'b1;
    end else if ((READ_IN || WRITE_IN) && wait_reg) begin
      wait_reg <= 1'b0;
    end else begin
      wait_reg <= 1'b1;
    end
  end

  // Read data captured only for reads, so a write leaves the last answer standing
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      rdata_reg <= 32'h00000000;
    end else if (READ_IN && wait_reg) begin
      rdata_reg <= rdata_next;
    end
  end

  // Channel mode register with byte lanes
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      mode_reg <= MODE_RESET;
    end else if (wr_take && ADDRESS_IN == ADDR_MODE) begin
      if (BYTEENABLE_IN[0]) begin
        mode_reg[7:0] <= WRITEDATA_IN[7:0];
      end
      if (BYTEENABLE_IN[1]) begin
        mode_reg[15:8] <= WRITEDATA_IN[15:8];
      end
    end
  end

  // Interrupt enable register
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      irq_enable_reg <= IRQ_RESET;
    end else if (wr_take && ADDRESS_IN == ADDR_IRQ_ENABLE && BYTEENABLE_IN[0]) begin
      irq_enable_reg <= WRITEDATA_IN[7:0];
    end
  end

  // Sticky status, a new fault wins over a clear in the same cycle
  assign clr_bits = (wr_take && ADDRESS_IN == ADDR_IRQ_CLEAR && BYTEENABLE_IN[0]) ?
                    WRITEDATA_IN[7:0] : 8'h00;

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      irq_status_reg <= IRQ_RESET;
      irq_reg <= 1'b0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~clr_bits) | evt_w;
      irq_reg <= |(((irq_status_reg & ~clr_bits) | evt_w) & irq_enable_reg);
    end
  end

  assign READDATA_OUT = rdata_reg;
  assign WAITREQUEST_OUT = wait_reg;
  assign GATE_ON_OUT = gate_w;
  assign DIAG_CURRENT_EN_OUT = cur_w;
  assign IRQ_OUT = irq_reg;

endmodule
`default_nettype wire

// file: cfd_diag_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module cfd_diag_monitor
  import cfd_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic READ_IN,
  input wire logic WRITE_IN,
  input wire logic WAITREQUEST_OUT,
  input wire logic [31:0] READDATA_OUT,
  input wire logic [7:0] OVERLOAD_IN,
  input wire logic [7:0] THERMAL_TRIP_IN,
  input wire logic [7:0] GATE_ON_OUT,
  input wire logic [7:0] DIAG_CURRENT_EN_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  logic [12:0] ovl_cnt;
  logic wr_done;
  // Cycles with channel 0 both overloaded and driven
  always_ff @(posedge CLK_IN) begin
    if (RST_IN || !(OVERLOAD_IN[0] && GATE_ON_OUT[0])) ovl_cnt <= '0;
    else ovl_cnt <= ovl_cnt + 13'h1;
  end
  assign wr_done = WRITE_IN && !WAITREQUEST_OUT;
  // Bus answer: one low cycle of waitrequest, then high again
  sequence req_s;
    (READ_IN || WRITE_IN) && WAITREQUEST_OUT;
  endsequence
  sequence ans_s;
    !WAITREQUEST_OUT ##1 WAITREQUEST_OUT;
  endsequence
  req_answer_a: assert property (req_s |=> ans_s) else $error("bus answer late");
  wait_pulse_a: assert property (!WAITREQUEST_OUT |=> WAITREQUEST_OUT) else $error("wait low twice");
  wait_idle_a: assert property (!(READ_IN || WRITE_IN) && WAITREQUEST_OUT |=> WAITREQUEST_OUT)
    else $error("answer without request");
  rdata_hold_a: assert property (!(READ_IN && WAITREQUEST_OUT) |=> $stable(READDATA_OUT))
    else $error("read data moved");
  trip_gate_a: assert property (THERMAL_TRIP_IN[2] |-> ##3 !GATE_ON_OUT[2])
    else $error("gate on while hot");
  trip_rise_a: assert property ($rose(GATE_ON_OUT[2]) |-> !$past(THERMAL_TRIP_IN[2], 3))
    else $error("gate rose while hot");
  ovl_limit_a: assert property (ovl_cnt <= 13'(OVL_DELAY_CYC + 4))
    else $error("overload not shut off");
  cur_write_a: assert property ($changed(DIAG_CURRENT_EN_OUT) |->
    $past(wr_done) || $past(wr_done, 2) || $past(RST_IN, 2))
    else $error("current source change without write");
endmodule
bind cfd_diag cfd_diag_monitor u_mon (.CLK_IN, .RST_IN, .READ_IN, .WRITE_IN, .WAITREQUEST_OUT,
  .READDATA_OUT, .OVERLOAD_IN, .THERMAL_TRIP_IN, .GATE_ON_OUT, .DIAG_CURRENT_EN_OUT);
`default_nettype wire

// file: cfd_host.sv
`timescale 1ns/1ps
`default_nettype none
module cfd_host (
  input wire logic clk_in,
  input wire logic wait_in,
  output logic [4:0] addr_out,
  output logic read_out,
  output logic write_out,
  output logic [31:0] data_out
);
  initial {addr_out, read_out, write_out, data_out} = '0;
  // One request, held until the edge that sees waitrequest low
  task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_out <= a;
    data_out <= d;
    write_out <= w;
    read_out <= !w;
    do @(posedge clk_in); while (wait_in !== 1'b0);
    {read_out, write_out} <= 2'b00;
  endtask
endmodule
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cfd_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rd, wr, wreq, irq;
  logic [4:0] addr;
  logic [31:0] wdata, rdata, r;
  logic [7:0] pin, above, below, ovl, trip, clamp, gate, cur;
  logic [31:0] expq[$];
  int err_count = 0;
  int check_count = 0;
  int cycles = 0;
  int seed = 23919;
  cfd_diag #(.OFF_FILT_CYC(16'h0008)) u_cfd_diag (.CLK_IN(clk), .RST_IN(rst), .ADDRESS_IN(addr),
    .READ_IN(rd), .WRITE_IN(wr), .WRITEDATA_IN(wdata), .BYTEENABLE_IN(4'hF),
    .READDATA_OUT(rdata), .WAITREQUEST_OUT(wreq), .PARALLEL_INPUT_IN(pin),
    .ABOVE_OPEN_LOAD_THRESHOLD_IN(above), .BELOW_GROUND_SHORT_THRESHOLD_IN(below),
    .OVERLOAD_IN(ovl), .THERMAL_TRIP_IN(trip), .CLAMPING_IN(clamp), .GATE_ON_OUT(gate),
    .DIAG_CURRENT_EN_OUT(cur), .IRQ_OUT(irq));
  cfd_host u_cfd_host (.clk_in(clk), .wait_in(wreq), .addr_out(addr), .read_out(rd),
    .write_out(wr), .data_out(wdata));
  // Clock and cycle limit
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrr(input logic [4:0] a, input logic [31:0] d);
    u_cfd_host.xfer(1'b1, a, d);
  endtask
  task automatic rdr(input logic [4:0] a, input logic [31:0] e);
    expq.push_back(e);
    u_cfd_host.xfer(1'b0, a, 32'h0);
  endtask
  task automatic gap(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Read results against the oldest expectation
  always @(posedge clk) begin
    if (rd && wreq === 1'b0 && expq.size() > 0) chk(rdata, expq.pop_front());
  end
  initial begin
    {pin, below, ovl, trip, clamp} = '0;
    above = 8'hFF;
    gap(4);
    rst <= 1'b0;
    pin <= 8'($random(seed));
    r = $random(seed);
    rdr(ADDR_MODE, 32'hFFFF);
    rdr(ADDR_DIAG, 32'h0);
    rdr(5'h14, 32'h0);
    rdr(ADDR_IRQ_CLEAR, 32'h0);
    wrr(ADDR_DIAG, 32'hFFFF);
    rdr(ADDR_DIAG, 32'h0);
    wrr(ADDR_IRQ_ENABLE, r);
    rdr(ADDR_IRQ_ENABLE, r & 32'hFF);
    wrr(ADDR_IRQ_ENABLE, 32'hFF);
    wrr(ADDR_MODE, 32'h0);
    wrr(ADDR_MODE, 32'hFFFF);
    chk({31'h0, (OFF_FILT_CYC >= 3750) && (OFF_FILT_CYC <= 25000)}, 32'h1);
    $display("registers done");
    above[1] <= 1'b0;
    gap(2);
    rdr(ADDR_DIAG, 32'h0);
    gap(20);
    rdr(ADDR_DIAG, 32'h4);
    rdr(ADDR_IRQ_STATUS, 32'h2);
    chk({31'h0, irq}, 32'h1);
    wrr(ADDR_IRQ_ENABLE, 32'h0);
    gap(3);
    chk({31'h0, irq}, 32'h0);
    wrr(ADDR_IRQ_ENABLE, 32'hFF);
    wrr(ADDR_IRQ_CLEAR, 32'hFF);
    gap(3);
    chk({31'h0, irq}, 32'h0);
    below[1] <= 1'b1;
    gap(20);
    rdr(ADDR_DIAG, 32'h8);
    below[1] <= 1'b0;
    gap(20);
    rdr(ADDR_DIAG, 32'h8);
    wrr(ADDR_MODE, 32'hFFF3);
    gap(3);
    chk({24'h0, cur}, 32'hFD);
    rdr(ADDR_DIAG, 32'h0);
    wrr(ADDR_MODE, 32'hFFFF);
    gap(20);
    rdr(ADDR_DIAG, 32'h4);
    $display("off state done");
    above <= 8'hFE;
    wrr(ADDR_MODE, 32'h0);
    wrr(ADDR_MODE, 32'hFFFF);
    gap(20);
    rdr(ADDR_DIAG, 32'h1);
    wrr(ADDR_MODE, 32'hFFFD);
    above <= 8'hFF;
    gap(5);
    chk({24'h0, gate}, 32'h1);
    ovl <= 8'h05;
    gap(2400);
    rdr(ADDR_DIAG, 32'h1);
    chk({24'h0, gate}, 32'h1);
    gap(120);
    rdr(ADDR_DIAG, 32'h3);
    chk({24'h0, gate}, 32'h0);
    ovl <= 8'h00;
    below[0] <= 1'b1;
    wrr(ADDR_MODE, 32'hFFFF);
    gap(20);
    rdr(ADDR_DIAG, 32'h3);
    wrr(ADDR_MODE, 32'hFFFC);
    wrr(ADDR_MODE, 32'hFFFF);
    gap(20);
    rdr(ADDR_DIAG, 32'h2);
    below[0] <= 1'b0;
    wrr(ADDR_MODE, 32'h0);
    $display("overload done");
    wrr(ADDR_MODE, 32'hFFFF);
    trip[2] <= 1'b1;
    gap(200);
    rdr(ADDR_DIAG, 32'h0);
    trip[2] <= 1'b0;
    gap(5);
    wrr(ADDR_MODE, 32'hFFDF);
    gap(5);
    chk({24'h0, gate}, 32'h4);
    trip[2] <= 1'b1;
    gap(140);
    rdr(ADDR_DIAG, 32'h30);
    trip[2] <= 1'b0;
    gap(8);
    chk({24'h0, gate}, 32'h0);
    wrr(ADDR_MODE, 32'hFFCF);
    wrr(ADDR_MODE, 32'hFFDF);
    gap(5);
    chk({24'h0, gate}, 32'h4);
    wrr(ADDR_MODE, 32'hFFBF);
    gap(5);
    chk({24'h0, gate}, {28'h0, pin[3], 3'h0});
    pin[3] <= ~pin[3];
    gap(6);
    chk({24'h0, gate}, {28'h0, pin[3], 3'h0});
    $display("thermal and input done");
    clamp[4] <= 1'b1;
    trip[4] <= 1'b1;
    gap(140);
    rdr(ADDR_DIAG, 32'h300);
    trip[4] <= 1'b0;
    wrr(ADDR_MODE, 32'hFCBF);
    wrr(ADDR_MODE, 32'hFDBF);
    gap(5);
    chk({24'h0, gate & 8'h10}, 32'h0);
    clamp[4] <= 1'b0;
    wrr(ADDR_MODE, 32'hFCBF);
    wrr(ADDR_MODE, 32'hFDBF);
    gap(5);
    chk({24'h0, gate & 8'h10}, 32'h10);
    $display("clamp done");
    gap(4);
    test_done();
  end
endmodule
`default_nettype wire
